// ===== rtl/perf_monitor_control_config.sv
`timescale 1ns/1ps
`include "pmu_defines.svh"
// What this block does
// - control access errors when off or locked; read-only under software lock
// - control bits 6..0 are shared with the internal system register view
// - warm or cold reset loads reset values; debug reset leaves control alone
// - control bits 31..7 read zero, writes ignored; software uses read-modify-write
// - cycle overflow on bit 31 wrap, or bit 63 wrap in long mode
// - prohibit-disable stops cycle counting while low counters are prohibited
// - events exported only while export bit set and counting not prohibited
// - overflow requests ignore the export bit
// - enabled cycle counter counts every clock, or once per 64 with divider
// - long mode ignores the divider and counts every clock
// - writing one to cycle-reset clears the cycle counter; reads zero
// - cycle-reset suppresses the cycle overflow pulse of a wrap in the same cycle
// - writing one to event-reset zeroes event counters only; no overflow clear
// - hypervisor-reserved counters survive event-reset while access-disable is set
// - global enable off stops low counters and cycle counter; on defers to enables
// - partition limit is hypervisor limit, else counter count; upper counters unaffected
// - configuration fixed fields: zero features, cycle flag one, prescale one
// - export-supported flag reflects whether the export bit is writable
// - configuration size field reads all ones for 64-bit counters
// - configuration low byte reports event counters, at most 31
// - counter-number field returns hypervisor limit while access-disable is set
// - configuration read-only when powered and unlocked, otherwise error
module perf_monitor_control_config (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	// debug access port
	input  wire logic                 dbgReq,
	input  wire logic                 dbgWrite,
	input  wire logic [11:0]          dbgAddr,
	input  wire pmu_pkg::word_t       dbgWdata,
	output      logic                 dbgAck,
	output      logic                 dbgErr,
	output      pmu_pkg::word_t       dbgRdata,
	// access conditions from the core
	input  wire logic                 corePowered,
	input  wire logic                 doubleLock,
	input  wire logic                 osLock,
	input  wire logic                 softwareLock,
	input  wire logic                 externalPmuAccessDisable,
	// internal system register view
	input  wire logic                 sysWrite,
	input  wire logic [6:0]           sysWdata,
	output      logic [6:0]           internalMonitorControl,
	// counter steering
	input  wire logic [4:0]           hypervisorPartitionLimit,
	input  wire logic [3:0]           countEnableSet,
	input  wire logic                 cycleEnableSet,
	input  wire logic                 countingProhibited,
	input  wire logic [3:0]           eventsIn,
	output      logic [3:0]           eventEnable,
	output      logic [3:0]           eventReset,
	output      logic [3:0]           exportedEvents,
	// cycle counter
	output      pmu_pkg::count_t      cycleCounter,
	output      logic                 cycleOverflow
);
	import pmu_pkg::*;

	// control register state
	logic       enableBit;
	logic       dividerBit;
	logic       exportBit;
	logic       prohibitCycleDisable;
	logic       longCycleOverflow;

	// decode
	reg_sel_t   regSel;
	wire        accessAllowed;
	wire        refused;
	wire        extCtrlWrite;
	wire        ctrlWrite;
	wire [6:0]  writeBits;
	wire        cycleClear;
	wire        eventClear;
	wire [4:0]  partitionLimit;
	wire [7:0]  counterNumber;
	wire        cycleRun;
	word_t      controlValue;
	word_t      configValue;
	word_t      next_rdata;

	// one-hot select from the address; anything else is unmapped
	assign regSel = (dbgAddr == `OFF_CONFIGURATION) ? SEL_CONFIG :
	                (dbgAddr == `OFF_CONTROL)       ? SEL_CONTROL : SEL_NONE;

	// off, locked or disabled gives error
	assign accessAllowed = corePowered & ~doubleLock & ~osLock & ~externalPmuAccessDisable;
	assign refused = ~accessAllowed | (regSel == SEL_NONE);

	// software lock makes the control read-only
	assign extCtrlWrite = dbgReq & dbgWrite & (regSel == SEL_CONTROL) & accessAllowed & ~softwareLock;

	// both views write the same bits
	assign ctrlWrite = extCtrlWrite | sysWrite;
	// the debug port wins if both write in one cycle; the core can retry, the debugger cannot see it
	assign writeBits = extCtrlWrite ? dbgWdata[6:0] : sysWdata;

	// write-only strobes for the cycle counter and the event counters
	assign cycleClear = ctrlWrite & writeBits[`CTRL_CYCLE_RESET];
	assign eventClear = ctrlWrite & writeBits[`CTRL_EVENT_RESET];

	assign partitionLimit = `EL2_IMPLEMENTED ? hypervisorPartitionLimit : `EVENT_COUNTERS;

	// event counter count in the low byte
	// hypervisor limit while access-disable is set
	// access-disable also refuses every debug access, so this substitution is
	// invisible on this port today; it is kept for a path that bypasses the refusal
	assign counterNumber = (`EL2_IMPLEMENTED && externalPmuAccessDisable) ?
	                       {3'h0, hypervisorPartitionLimit} : {3'h0, `EVENT_COUNTERS};

	assign configValue = {`CFG_GROUPS, `CFG_RESERVED, `CFG_USER_ENABLE, `CFG_WT, `CFG_NA,
	                      `EXPORT_IMPLEMENTED, `CFG_PRESCALE, `CFG_DEDICATED, `CFG_SIZE, counterNumber};

	assign controlValue = {25'h0000000, longCycleOverflow, prohibitCycleDisable, exportBit,
	                       dividerBit, 1'b0, 1'b0, enableBit};

	// read data mux; writes and errors return zero
	assign next_rdata = (refused || dbgWrite)      ? 32'h00000000 :
	                    (regSel == SEL_CONFIG)     ? configValue  : controlValue;

	// global enable gates the cycle counter
	assign cycleRun = enableBit & cycleEnableSet & ~(prohibitCycleDisable & countingProhibited);

	// access answer one cycle after the request
	// every request is answered, so the agent never has to time out on a refused access
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dbgAck   <= 1'b0;
			dbgErr   <= 1'b0;
			dbgRdata <= 32'h00000000;
		end else begin
			dbgAck   <= dbgReq;
			dbgErr   <= dbgReq & refused;
			dbgRdata <= dbgReq ? next_rdata : 32'h00000000;
		end
	end

	// warm or cold reset values; no debug reset input reaches this register
	// the long-cycle bit has no defined warm value; zero keeps a fresh counter in short mode
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			enableBit            <= `RST_ENABLE;
			dividerBit           <= `RST_DIVIDER;
			exportBit            <= `RST_EXPORT;
			prohibitCycleDisable <= `RST_PROHIBIT;
			longCycleOverflow    <= `RST_LONG_CYCLE;
		end else if (ctrlWrite) begin
			enableBit            <= writeBits[`CTRL_ENABLE];
			dividerBit           <= writeBits[`CTRL_DIVIDER];
			exportBit            <= writeBits[`CTRL_EXPORT] & `EXPORT_IMPLEMENTED;
			prohibitCycleDisable <= writeBits[`CTRL_PROHIBIT];
			longCycleOverflow    <= writeBits[`CTRL_LONG_CYCLE];
		end
	end

	// internal view of the shared bits
	assign internalMonitorControl = {longCycleOverflow, prohibitCycleDisable, exportBit,
	                                 dividerBit, 1'b0, 1'b0, enableBit};

	// per event counter: enable gating, reset strobe and export
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_event
			wire lowCounter;
			wire reserved;
			// counters at or above the limit ignore the global enable
			assign lowCounter = (5'(i) < partitionLimit);
			assign reserved   = `EL2_IMPLEMENTED & externalPmuAccessDisable & (5'(i) >= hypervisorPartitionLimit);

			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					eventEnable[i]    <= 1'b0;
					eventReset[i]     <= 1'b0;
					exportedEvents[i] <= 1'b0;
				end else begin
					eventEnable[i]    <= lowCounter ? (enableBit & countEnableSet[i]) : countEnableSet[i];
					eventReset[i]     <= eventClear & ~reserved;
					exportedEvents[i] <= exportBit & ~countingProhibited & eventsIn[i];
				end
			end
		end
	endgenerate

	// overflow is reported whatever the export bit says
	cycle_counter_unit u_cycle (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.run      (cycleRun),
		.divide   (dividerBit),
		.longMode (longCycleOverflow),
		.clear    (cycleClear),
		.count    (cycleCounter),
		.overflow (cycleOverflow)
	);

	// ------------------------------------------------------------------
	// checks of the port behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// helper: what the previous read request addressed
	logic lastSelControl;
	logic lastSelConfig;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lastSelControl <= 1'b0;
			lastSelConfig  <= 1'b0;
		end else begin
			lastSelControl <= dbgReq & ~dbgWrite & (regSel == SEL_CONTROL);
			lastSelConfig  <= dbgReq & ~dbgWrite & (regSel == SEL_CONFIG);
		end
	end

	sequence s_refused_req;
		dbgReq && !accessAllowed;
	endsequence

	sequence s_error_answer;
		##1 dbgAck && dbgErr && dbgRdata == 32'h00000000;
	endsequence

	property p_locked_error;
		s_refused_req |-> s_error_answer;
	endproperty
	a_locked_error: assert property (p_locked_error) else $error("locked access not refused");

	property p_soft_lock_ro;
		dbgReq && dbgWrite && softwareLock && !refused && !sysWrite |=> $stable(internalMonitorControl) && !dbgErr;
	endproperty
	a_soft_lock_ro: assert property (p_soft_lock_ro) else $error("write passed software lock");

	property p_shared_view;
		sysWrite && !extCtrlWrite |=> internalMonitorControl[6:3] == $past(sysWdata[6:3])
		                           && internalMonitorControl[0] == $past(sysWdata[0]);
	endproperty
	a_shared_view: assert property (p_shared_view) else $error("system write not visible");

	property p_upper_zero;
		dbgAck && !dbgErr && lastSelControl |-> dbgRdata[31:7] == 25'h0000000 && dbgRdata[2:1] == 2'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("control upper bits not zero");

	property p_cycle_clear;
		cycleClear |=> cycleCounter == 64'h0000000000000000;
	endproperty
	a_cycle_clear: assert property (p_cycle_clear) else $error("cycle counter not cleared");

	property p_export_gate;
		exportedEvents != 4'h0 |-> $past(exportBit) && !$past(countingProhibited);
	endproperty
	a_export_gate: assert property (p_export_gate) else $error("event exported while blocked");

	property p_global_off;
		!enableBit && hypervisorPartitionLimit >= 5'h04 |=> eventEnable == 4'h0;
	endproperty
	a_global_off: assert property (p_global_off) else $error("counter enabled while global off");

	property p_config_fixed;
		dbgAck && !dbgErr && lastSelConfig |-> dbgRdata[31:17] == 15'h0000 && dbgRdata[15:8] == 8'hFF;
	endproperty
	a_config_fixed: assert property (p_config_fixed) else $error("configuration fields wrong");

	property p_reserved_kept;
		eventClear && externalPmuAccessDisable && hypervisorPartitionLimit == 5'h00 |=> eventReset == 4'h0;
	endproperty
	a_reserved_kept: assert property (p_reserved_kept) else $error("reserved counter reset");

	property p_prohibit_stop;
		prohibitCycleDisable && countingProhibited && !cycleClear |=> $stable(cycleCounter);
	endproperty
	a_prohibit_stop: assert property (p_prohibit_stop) else $error("cycle counted while prohibited");

	// answers, feature fields and reset state of the access port
	property p_ack_next;
		dbgReq |=> dbgAck;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");

	property p_err_with_ack;
		dbgErr |-> dbgAck;
	endproperty
	a_err_with_ack: assert property (p_err_with_ack) else $error("error without answer");

	sequence s_config_read;
		dbgReq && !dbgWrite && regSel == SEL_CONFIG && accessAllowed;
	endsequence

	sequence s_config_answer;
		dbgAck && !dbgErr && lastSelConfig;
	endsequence

	property p_config_readable;
		s_config_read |=> s_config_answer;
	endproperty
	a_config_readable: assert property (p_config_readable) else $error("allowed config read refused");

	// a write to the configuration is dropped without touching control
	property p_config_no_write;
		dbgReq && dbgWrite && regSel == SEL_CONFIG && !sysWrite |=> $stable(internalMonitorControl);
	endproperty
	a_config_no_write: assert property (p_config_no_write) else $error("config write took effect");

	property p_counter_number;
		s_config_answer |-> dbgRdata[7:0] == {3'h0, `EVENT_COUNTERS};
	endproperty
	a_counter_number: assert property (p_counter_number) else $error("counter number wrong");

	property p_export_flag;
		s_config_answer |-> dbgRdata[16] == `EXPORT_IMPLEMENTED;
	endproperty
	a_export_flag: assert property (p_export_flag) else $error("export-supported flag wrong");

	// reset values must be in place at the first edge after release
	property p_reset_clean;
		$rose(reset_n) |-> internalMonitorControl == 7'h00 && !dbgAck;
	endproperty
	a_reset_clean: assert property (p_reset_clean) else $error("control not at reset values");

	property p_event_reset_all;
		eventClear && !externalPmuAccessDisable |=> eventReset == 4'hF;
	endproperty
	a_event_reset_all: assert property (p_event_reset_all) else $error("event counter not reset");

	// with a zero limit every counter is outside the global enable
	property p_upper_free;
		hypervisorPartitionLimit == 5'h00 |=> eventEnable == $past(countEnableSet);
	endproperty
	a_upper_free: assert property (p_upper_free) else $error("upper counter gated by enable");
endmodule : perf_monitor_control_config

// ===== rtl/pmu_defines.svh
`ifndef PMU_DEFINES_SVH
`define PMU_DEFINES_SVH

// register offsets on the debug access port
`define OFF_CONFIGURATION 12'hE00
`define OFF_CONTROL       12'hE04

// control register field positions
`define CTRL_ENABLE        0
`define CTRL_EVENT_RESET   1
`define CTRL_CYCLE_RESET   2
`define CTRL_DIVIDER       3
`define CTRL_EXPORT        4
`define CTRL_PROHIBIT      5
`define CTRL_LONG_CYCLE    6

// control register reset values
`define RST_ENABLE         1'h0
`define RST_DIVIDER        1'h0
`define RST_EXPORT         1'h0
`define RST_PROHIBIT       1'h0
`define RST_LONG_CYCLE     1'h0

// implementation choices
`define EVENT_COUNTERS     5'h04
`define EL2_IMPLEMENTED    1'h1
`define EXPORT_IMPLEMENTED 1'h1

// configuration register fixed fields
`define CFG_GROUPS         4'h0
`define CFG_RESERVED       8'h00
`define CFG_USER_ENABLE    1'h0
`define CFG_WT             1'h0
`define CFG_NA             1'h0
`define CFG_PRESCALE       1'h1
`define CFG_DEDICATED      1'h1
`define CFG_SIZE           6'h3F

// cycle counter prescale: one count per 64 clocks
`define PRESCALE_LAST      6'h3F
`define LOW_WRAP           32'hFFFFFFFF

`endif

// ===== rtl/pmu_pkg.sv
package pmu_pkg;
	typedef logic [31:0] word_t;
	typedef logic [63:0] count_t;
	// one-hot register select of the access port
	typedef enum logic [2:0] {
		SEL_NONE    = 3'h1,
		SEL_CONFIG  = 3'h2,
		SEL_CONTROL = 3'h4
	} reg_sel_t;
endpackage : pmu_pkg

// ===== rtl/cycle_counter_unit.sv
`timescale 1ns/1ps
`include "pmu_defines.svh"
module cycle_counter_unit (
	// clock and reset
	input  wire logic           core_clk,
	input  wire logic           reset_n,
	// steering
	input  wire logic           run,
	input  wire logic           divide,
	input  wire logic           longMode,
	input  wire logic           clear,
	// state
	output      pmu_pkg::count_t count,
	output      logic           overflow
);
	import pmu_pkg::*;

	logic [5:0] prescale;
	wire        divideEff;
	wire        tick;
	wire        wrapNow;

	assign divideEff = divide & ~longMode;
	// every clock or once per 64
	assign tick      = run & (~divideEff | (prescale == `PRESCALE_LAST));
	// overflow bit chosen by long mode
	assign wrapNow   = longMode ? (&count) : (count[31:0] == `LOW_WRAP);

	// prescaler only runs while dividing, so a stopped counter keeps its phase
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale <= 6'h00;
		end else if (run && divideEff) begin
			prescale <= prescale + 6'h01;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 64'h0000000000000000;
		end else if (clear) begin
			count <= 64'h0000000000000000;
		end else if (tick) begin
			count <= count + 64'h0000000000000001;
		end
	end

	// clearing wins over a wrap and drops the overflow report, which is only a pulse on wrap
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			overflow <= 1'b0;
		end else begin
			overflow <= tick & ~clear & wrapNow;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	property p_div_hold;
		run && divideEff && !clear && prescale != `PRESCALE_LAST |=> count == $past(count);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divided counter moved early");

	property p_long_every;
		run && longMode && !clear |=> count == $past(count) + 64'h0000000000000001;
	endproperty
	a_long_every: assert property (p_long_every) else $error("long counter missed a clock");

	property p_wrap_low;
		overflow && !$past(longMode) |-> $past(count[31]) && !count[31];
	endproperty
	a_wrap_low: assert property (p_wrap_low) else $error("overflow without bit 31 wrap");
endmodule : cycle_counter_unit

// ===== bench/debug_agent.sv
`timescale 1ns/1ps
// debug agent: one request per call, qualifiers scrambled once released
module debug_agent (
	// clock
	input  wire logic            core_clk,
	// debug access port
	output      logic            dbgReq,
	output      logic            dbgWrite,
	output      logic [11:0]     dbgAddr,
	output      pmu_pkg::word_t  dbgWdata
);
	import pmu_pkg::*;
	initial begin
		dbgReq = 1'h0;
		dbgWrite = 1'h0;
		dbgAddr = 12'h000;
		dbgWdata = 32'h00000000;
	end
	// rel=0 keeps the strobe up so the next access goes back to back
	task automatic access(input logic w, input logic [11:0] a, input word_t d, input logic rel);
		// an idle edge after a release keeps each strobe to one change per step
		if (!dbgReq) begin
			@(posedge core_clk);
			#1;
		end
		dbgReq = 1'h1;
		dbgWrite = w;
		dbgAddr = a;
		dbgWdata = d;
		@(posedge core_clk);
		#1;
		if (rel) begin
			dbgReq = 1'h0;
			dbgWrite = ~w;
			dbgAddr = ~a;
			dbgWdata = ~d;
		end
	endtask : access
endmodule : debug_agent

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "pmu_defines.svh"
module testbench;
	import pmu_pkg::*;
	typedef struct packed {logic err; word_t data;} resp_t;
	logic core_clk = 0, reset_n = 0, corePowered = 1, doubleLock = 0, osLock = 0, softwareLock = 0;
	logic externalPmuAccessDisable = 0, sysWrite = 0, cycleEnableSet = 0, countingProhibited = 0;
	logic [6:0] sysWdata = 0, shadow = 0, hold;
	logic [4:0] hypervisorPartitionLimit = 5'h02;
	logic [3:0] countEnableSet = 0, eventsIn = 0, expEn;
	logic dbgReq, dbgWrite, dbgAck, dbgErr;
	logic [11:0] dbgAddr;
	word_t dbgWdata, dbgRdata;
	logic [6:0] internalMonitorControl;
	logic [3:0] eventEnable, eventReset, exportedEvents;
	count_t cycleCounter, base;
	logic cycleOverflow;
	resp_t expQ[$], resp;
	int mismatches = 0, num_checks = 0, seed = 4630;
	// counter groups, features zero; export, prescale, dedicated set; size all ones; four counters
	localparam word_t CFG_EXP = {4'h0, 8'h00, 3'h0, 1'h1, 1'h1, 1'h1, 6'h3F, 8'h04};
	always #12.5 core_clk = ~core_clk;
	debug_agent agent (.core_clk(core_clk), .dbgReq(dbgReq), .dbgWrite(dbgWrite), .dbgAddr(dbgAddr),
		.dbgWdata(dbgWdata));
	perf_monitor_control_config uut (.core_clk(core_clk), .reset_n(reset_n), .dbgReq(dbgReq),
		.dbgWrite(dbgWrite), .dbgAddr(dbgAddr), .dbgWdata(dbgWdata), .dbgAck(dbgAck), .dbgErr(dbgErr),
		.dbgRdata(dbgRdata), .corePowered(corePowered), .doubleLock(doubleLock), .osLock(osLock),
		.softwareLock(softwareLock), .externalPmuAccessDisable(externalPmuAccessDisable),
		.sysWrite(sysWrite), .sysWdata(sysWdata), .internalMonitorControl(internalMonitorControl),
		.hypervisorPartitionLimit(hypervisorPartitionLimit), .countEnableSet(countEnableSet),
		.cycleEnableSet(cycleEnableSet), .countingProhibited(countingProhibited), .eventsIn(eventsIn),
		.eventEnable(eventEnable), .eventReset(eventReset), .exportedEvents(exportedEvents),
		.cycleCounter(cycleCounter), .cycleOverflow(cycleOverflow));
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	// answers are matched to the oldest note, so a lost or extra ack shows up
	always @(posedge core_clk) begin
		if (dbgAck === 1'b1) begin
			if (expQ.size() == 0) check("spare ack", 0, 1);
			else begin
				resp = expQ.pop_front();
				check("dbgErr", resp.err, dbgErr);
				check("dbgRdata", resp.data, dbgRdata);
			end
		end
	end
	task automatic xfer(input logic w, input logic [11:0] a, input word_t d, input logic e, input word_t r,
		input logic rel = 1);
		expQ.push_back('{e, r});
		agent.access(w, a, d, rel);
	endtask : xfer
	// write straight through, the shadow keeps the expected bits; upper bits and strobes fall away
	task automatic wrCtrl(input word_t d, input logic rel = 1);
		if (!softwareLock) shadow = d[6:0] & 7'h79;
		xfer(1, `OFF_CONTROL, d, 0, 0, rel);
	endtask : wrCtrl
	task automatic rdCtrl;
		xfer(0, `OFF_CONTROL, 0, 0, {25'h0, shadow});
	endtask : rdCtrl
	task automatic cnt(input int n, input logic [63:0] delta);
		@(posedge core_clk);
		#1;
		base = cycleCounter;
		repeat (n) @(posedge core_clk);
		#1;
		check("cycleCounter", base + delta, cycleCounter);
		check("cycleOverflow", 0, cycleOverflow);
	endtask : cnt
	initial begin
		#(25 * 6000);
		mismatches++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		#1 reset_n = 1;
		rdCtrl();
		xfer(0, `OFF_CONFIGURATION, 0, 0, CFG_EXP);
		xfer(1, `OFF_CONFIGURATION, $random(seed), 0, 0);
		xfer(0, `OFF_CONFIGURATION, 0, 0, CFG_EXP);
		// back-to-back write then read
		repeat (6) begin
			wrCtrl($random(seed), 0);
			rdCtrl();
			check("internalMonitorControl", shadow, internalMonitorControl);
		end
		sysWrite = 1;
		sysWdata = 7'($random(seed));
		@(posedge core_clk);
		#1 sysWrite = 0;
		shadow = sysWdata & 7'h79;
		check("internalMonitorControl", shadow, internalMonitorControl);
		rdCtrl();
		softwareLock = 1;
		wrCtrl({25'h0, ~shadow});
		rdCtrl();
		softwareLock = 0;
		// error table, last entry an unmapped offset
		for (int i = 0; i < 5; i++) begin
			corePowered = (i != 0);
			doubleLock = (i == 1);
			osLock = (i == 2);
			externalPmuAccessDisable = (i == 3);
			xfer(0, (i == 4) ? 12'hE08 : `OFF_CONTROL, 0, 1, 0);
			xfer(1, (i == 4) ? 12'hE08 : `OFF_CONTROL, 32'h79, 1, 0);
			if (i < 4) xfer(0, `OFF_CONFIGURATION, 0, 1, 0);
		end
		corePowered = 1;
		rdCtrl();
		cycleEnableSet = 1;
		wrCtrl(32'h1);
		cnt(10, 10);
		wrCtrl(32'h9);
		cnt(128, 2);
		wrCtrl(32'h49);
		cnt(10, 10);
		wrCtrl(32'h21);
		countingProhibited = 1;
		cnt(10, 0);
		countingProhibited = 0;
		cnt(10, 10);
		cycleEnableSet = 0;
		cnt(10, 0);
		cycleEnableSet = 1;
		wrCtrl(32'h0);
		cnt(10, 0);
		// reset strobes act once and read zero
		wrCtrl(32'h7);
		check("cycleCounter", 0, cycleCounter);
		check("eventReset", 4'hF, eventReset);
		@(posedge core_clk);
		#1 check("eventReset", 0, eventReset);
		rdCtrl();
		// every mix of enable, export and prohibit
		for (int j = 0; j < 8; j++) begin
			wrCtrl({27'h0, j[1], 3'h0, j[0]});
			countingProhibited = j[2];
			countEnableSet = 4'($random(seed));
			eventsIn = 4'($random(seed));
			// counters at or above the limit ignore the global enable
			hypervisorPartitionLimit = 5'(j + 1);
			for (int k = 0; k < 4; k++) expEn[k] = countEnableSet[k] & (j[0] | (k > j));
			repeat (2) @(posedge core_clk);
			#1;
			if (!j[2]) check("eventEnable", expEn, eventEnable);
			check("exportedEvents", (j[1] && !j[2]) ? eventsIn : 4'h0, exportedEvents);
		end
		// system event-reset spares counters reserved at or above the limit
		externalPmuAccessDisable = 1;
		hypervisorPartitionLimit = 5'h02;
		sysWdata = 7'h02;
		sysWrite = 1;
		@(posedge core_clk);
		#1 hypervisorPartitionLimit = 5'h00;
		check("eventReset", 4'h3, eventReset);
		@(posedge core_clk);
		#1 sysWrite = 0;
		check("eventReset", 4'h0, eventReset);
		check("internalMonitorControl", 0, internalMonitorControl);
		externalPmuAccessDisable = 0;
		shadow = 0;
		// reset in mid-run restores reset values; the write is answered first
		wrCtrl(32'h79);
		@(posedge core_clk);
		#1 reset_n = 0;
		repeat (3) @(posedge core_clk);
		#1 reset_n = 1;
		shadow = 0;
		check("internalMonitorControl", 0, internalMonitorControl);
		rdCtrl();
		repeat (3) @(posedge core_clk);
		check("pending answers", 0, expQ.size());
		final_report();
	end
endmodule : testbench
